/* scfpt_pkg.sv */
`default_nettype none

package scfpt_pkg;

    // Clock rate of ref_clk
    localparam int unsigned REF_CLK_HZ = 100_000_000;

    // Self-timed cycle maxima, in their printed units
    localparam int unsigned PROG_MAX_MS       = 5;
    localparam int unsigned PROG_MAX_LARGE_MS = 7;
    localparam int unsigned WSTAT_MAX_MS      = 15;
    localparam int unsigned BULK_MAX_SMALL_S  = 6;
    localparam int unsigned BULK_MAX_LARGE_S  = 250;
    localparam int unsigned SECT_MAX_S        = 3;
    localparam int unsigned SECT_MAX_LARGE_S  = 6;

    // Cycle counts derived from the times (millisecond times round down)
    localparam longint unsigned PROG_CYC =
        longint'(PROG_MAX_MS) * REF_CLK_HZ / 1000;
    localparam longint unsigned PROG_LARGE_CYC =
        longint'(PROG_MAX_LARGE_MS) * REF_CLK_HZ / 1000;
    localparam longint unsigned WSTAT_CYC =
        longint'(WSTAT_MAX_MS) * REF_CLK_HZ / 1000;
    localparam longint unsigned BULK_SMALL_CYC =
        longint'(BULK_MAX_SMALL_S) * REF_CLK_HZ;
    localparam longint unsigned BULK_LARGE_CYC =
        longint'(BULK_MAX_LARGE_S) * REF_CLK_HZ;
    localparam longint unsigned SECT_CYC =
        longint'(SECT_MAX_S) * REF_CLK_HZ;
    localparam longint unsigned SECT_LARGE_CYC =
        longint'(SECT_MAX_LARGE_S) * REF_CLK_HZ;

    // Width of the busy-time counter
    localparam int unsigned CNT_W = 36;

    // Operation codes, most significant bit first on the link
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_PROG  = 8'h02;
    localparam logic [7:0] OP_BULK  = 8'hc7;
    localparam logic [7:0] OP_SECT  = 8'hd8;

    // Status register bit positions
    localparam int unsigned SR_WIP = 0;
    localparam int unsigned SR_WEL = 1;

    // Frame bit counts at the end of each field
    localparam int unsigned OP_BITS   = 8;
    localparam int unsigned ADDR_BITS = 32;
    localparam int unsigned DATA_BITS = 40;

    // Kinds of self-timed cycle
    typedef enum logic [2:0] {
        SCFPT_JOB_NONE,
        SCFPT_JOB_PROG,
        SCFPT_JOB_WSTAT,
        SCFPT_JOB_BULK,
        SCFPT_JOB_SECT
    } scfpt_job_t;

    // Power and cycle state
    typedef enum logic [1:0] {
        SCFPT_ST_STANDBY,
        SCFPT_ST_ACTIVE,
        SCFPT_ST_BUSY
    } scfpt_state_t;

endpackage

`default_nettype wire

/* scfpt_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module scfpt_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             ref_clk, // System clock
    input  wire logic             rst,     // Async reset, high
    input  wire logic [WIDTH-1:0] async_i, // Pin levels
    output logic      [WIDTH-1:0] sync_o   // Synchronised levels
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    // Two-stage capture; first stage feeds only the second
    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= meta_nxt;
            sync_o <= sync_nxt;
        end
    end

endmodule

`default_nettype wire

/* scfpt_core.sv */
`timescale 1ns/1ps
`default_nettype none

module scfpt_core
    import scfpt_pkg::*;
#(
    parameter logic            LARGE_DENSITY = 1'b0,
    parameter longint unsigned PROG_CYCLES   = PROG_CYC,
    parameter longint unsigned PROG_L_CYCLES = PROG_LARGE_CYC,
    parameter longint unsigned WSTAT_CYCLES  = WSTAT_CYC,
    parameter longint unsigned BULK_CYCLES   = BULK_SMALL_CYC,
    parameter longint unsigned BULK_L_CYCLES = BULK_LARGE_CYC,
    parameter longint unsigned SECT_CYCLES   = SECT_CYC,
    parameter longint unsigned SECT_L_CYCLES = SECT_LARGE_CYC
) (
    input  wire logic ref_clk,        // System clock, 100 MHz
    input  wire logic rst,            // Async reset, high
    input  wire logic chip_select_n,  // Chip select pin, low active
    input  wire logic serial_clock,   // Link clock from the host
    input  wire logic serial_data_in, // Link data from the host
    output logic      data_out,       // Serial data to the host
    output logic      data_out_oe,    // High while data_out is driven
    output logic      active_power,   // High in active power mode
    output logic      write_busy      // Write-in-progress flag
);

    // Refuse cycle counts that are zero or overflow the counter
    if (PROG_CYCLES == 0 || PROG_L_CYCLES == 0 || WSTAT_CYCLES == 0 ||
        BULK_CYCLES == 0 || BULK_L_CYCLES == 0 || SECT_CYCLES == 0 ||
        SECT_L_CYCLES == 0 ||
        PROG_CYCLES >= (64'h1 << CNT_W) ||
        PROG_L_CYCLES >= (64'h1 << CNT_W) ||
        WSTAT_CYCLES >= (64'h1 << CNT_W) ||
        BULK_CYCLES >= (64'h1 << CNT_W) ||
        BULK_L_CYCLES >= (64'h1 << CNT_W) ||
        SECT_CYCLES >= (64'h1 << CNT_W) ||
        SECT_L_CYCLES >= (64'h1 << CNT_W)) begin
        $error("scfpt_core: cycle counts out of range");
    end

    logic [2:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       sdi_s;

    // Pins pass two flops before use
    scfpt_sync #(.WIDTH(3)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .async_i ({chip_select_n, serial_clock, serial_data_in}),
        .sync_o  (pins_s)
    );
    assign {cs_n_s, sclk_s, sdi_s} = pins_s;

    // Busy time of each cycle kind
    function automatic logic [CNT_W-1:0] job_len(input scfpt_job_t j);
        longint unsigned n;
        n = 1;
        case (j)
            SCFPT_JOB_PROG:  n = LARGE_DENSITY ? PROG_L_CYCLES
                                               : PROG_CYCLES;
            SCFPT_JOB_WSTAT: n = WSTAT_CYCLES;
            SCFPT_JOB_BULK:  n = LARGE_DENSITY ? BULK_L_CYCLES
                                               : BULK_CYCLES;
            SCFPT_JOB_SECT:  n = LARGE_DENSITY ? SECT_L_CYCLES
                                               : SECT_CYCLES;
            default:         n = 1;
        endcase
        return n[CNT_W-1:0];
    endfunction

    scfpt_state_t     state_r,  state_nxt;
    logic             sclk_d_r, sclk_d_nxt;
    logic             cs_d_r,   cs_d_nxt;
    logic [7:0]       op_r,     op_nxt;
    logic [5:0]       bits_r,   bits_nxt;
    logic [7:0]       sh_r,     sh_nxt;
    logic             wel_r,    wel_nxt;
    logic             rdsr_r,   rdsr_nxt;
    logic [CNT_W-1:0] cnt_r,    cnt_nxt;
    logic             dout_r,   dout_nxt;
    logic             oe_r,     oe_nxt;
    scfpt_job_t       job;
    logic             rise;
    logic             fall;
    logic             cs_end;
    logic             busy;
    logic [7:0]       status;

    always_comb begin
        rise   = sclk_s & ~sclk_d_r & ~cs_n_s;
        fall   = ~sclk_s & sclk_d_r & ~cs_n_s;
        cs_end = cs_n_s & ~cs_d_r;
        busy   = (state_r == SCFPT_ST_BUSY);
        status = 8'h00;
        status[SR_WIP] = busy;
        status[SR_WEL] = wel_r;
    end

    // Frame decode: which cycle a closing chip select starts
    always_comb begin
        job = SCFPT_JOB_NONE;
        if (wel_r && !busy) begin
            case (op_r)
                OP_PROG: if (bits_r >= 6'(DATA_BITS) &&
                             bits_r[2:0] == 3'h0)
                             job = SCFPT_JOB_PROG;
                OP_WRSR: if (bits_r == 6'(OP_BITS + 8))
                             job = SCFPT_JOB_WSTAT;
                OP_BULK: if (bits_r == 6'(OP_BITS))
                             job = SCFPT_JOB_BULK;
                OP_SECT: if (bits_r == 6'(ADDR_BITS))
                             job = SCFPT_JOB_SECT;
                default: job = SCFPT_JOB_NONE;
            endcase
        end
    end

    // Next-state for link shifting, power state and cycle timing
    always_comb begin
        state_nxt  = state_r;
        sclk_d_nxt = sclk_s;
        cs_d_nxt   = cs_n_s;
        op_nxt     = op_r;
        bits_nxt   = bits_r;
        sh_nxt     = sh_r;
        wel_nxt    = wel_r;
        rdsr_nxt   = rdsr_r;
        cnt_nxt    = cnt_r;
        dout_nxt   = dout_r;
        oe_nxt     = 1'b0;
        if (!cs_n_s) begin
            oe_nxt = rdsr_r;
            if (state_r == SCFPT_ST_STANDBY)
                state_nxt = SCFPT_ST_ACTIVE;
            if (cs_d_r) begin
                bits_nxt = '0;
                rdsr_nxt = 1'b0;
            end else if (rise) begin
                if (bits_r < 6'(OP_BITS))
                    op_nxt = {op_r[6:0], sdi_s};
                // Past the first data byte, count modulo one byte
                if (bits_r == 6'(DATA_BITS + 7))
                    bits_nxt = 6'(DATA_BITS);
                else
                    bits_nxt = bits_r + 6'h01;
                if (bits_r == 6'(OP_BITS - 1)) begin
                    rdsr_nxt = ({op_r[6:0], sdi_s} == OP_RDSR);
                    sh_nxt   = status;
                end
            end else if (fall && rdsr_r) begin
                dout_nxt = sh_r[7];
                sh_nxt   = {sh_r[6:0], sh_r[7]};
                if (bits_r[2:0] == 3'h0) begin
                    // Fresh status byte, its top bit goes out now
                    dout_nxt = status[7];
                    sh_nxt   = {status[6:0], status[7]};
                end
            end
        end
        if (cs_end) begin
            rdsr_nxt = 1'b0;
            if (!busy && bits_r == 6'(OP_BITS) && op_r == OP_WREN)
                wel_nxt = 1'b1;
            if (!busy && bits_r == 6'(OP_BITS) && op_r == OP_WRDI)
                wel_nxt = 1'b0;
            if (job != SCFPT_JOB_NONE) begin
                state_nxt = SCFPT_ST_BUSY;
                cnt_nxt   = job_len(job) - CNT_W'(1);
                wel_nxt   = 1'b0;
            end else if (!busy) begin
                state_nxt = SCFPT_ST_STANDBY;
            end
        end
        // Cycle timer runs on through status reads
        if (busy) begin
            if (cnt_r == '0) begin
                wel_nxt   = 1'b0;
                state_nxt = cs_n_s ? SCFPT_ST_STANDBY
                                   : SCFPT_ST_ACTIVE;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r  <= SCFPT_ST_STANDBY;
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
            op_r     <= 8'h00;
            bits_r   <= 6'h00;
            sh_r     <= 8'h00;
            wel_r    <= 1'b0;
            rdsr_r   <= 1'b0;
            cnt_r    <= '0;
            dout_r   <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            sclk_d_r <= sclk_d_nxt;
            cs_d_r   <= cs_d_nxt;
            op_r     <= op_nxt;
            bits_r   <= bits_nxt;
            sh_r     <= sh_nxt;
            wel_r    <= wel_nxt;
            rdsr_r   <= rdsr_nxt;
            cnt_r    <= cnt_nxt;
            dout_r   <= dout_nxt;
            oe_r     <= oe_nxt;
        end
    end

    // Outputs: data_out and data_out_oe registered, power and busy decoded from state_r
    assign data_out     = dout_r;
    assign data_out_oe  = oe_r;
    assign active_power = (state_r != SCFPT_ST_STANDBY);
    assign write_busy   = busy;

endmodule

`default_nettype wire

/* scfpt_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module scfpt_sva #(
    parameter longint unsigned PROG_CYCLES  = 1,
    parameter longint unsigned WSTAT_CYCLES = 1,
    parameter longint unsigned BULK_CYCLES  = 1,
    parameter longint unsigned SECT_CYCLES  = 1
) (
    input wire logic ref_clk,       // System clock
    input wire logic rst,           // Async reset
    input wire logic chip_select_n, // Select pin
    input wire logic data_out_oe,   // Data enable
    input wire logic active_power,  // Power mode
    input wire logic write_busy     // Busy flag
);
    longint unsigned len_r;
    longint unsigned len_nxt;

    // Length of the current busy run
    always_comb begin
        len_nxt = write_busy ? len_r + 1 : '0;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            len_r <= '0;
        end else begin
            len_r <= len_nxt;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Power mode, cycle timing and output enable
    sel_wakes_a: assert property (
        $fell(chip_select_n) |-> ##[2:4] active_power)
        else $error("select did not wake the device");
    busy_awake_a: assert property (
        write_busy |-> active_power)
        else $error("standby during a cycle");
    idle_standby_a: assert property (
        (chip_select_n[*6] ##0 !write_busy) |-> !active_power)
        else $error("no standby when idle");
    desel_quiet_a: assert property (
        chip_select_n[*4] |-> !data_out_oe)
        else $error("data driven while deselected");
    cycle_len_a: assert property (
        $fell(write_busy) |-> len_r inside
        {PROG_CYCLES, WSTAT_CYCLES, BULK_CYCLES, SECT_CYCLES})
        else $error("cycle length wrong");
    cycle_max_a: assert property (
        write_busy |-> len_r < BULK_CYCLES)
        else $error("cycle too long");
    start_now_a: assert property (
        $rose(write_busy) |->
        $past(chip_select_n, 2) && !$past(chip_select_n, 5))
        else $error("cycle start not at deselect");
    busy_holds_a: assert property (
        $rose(write_busy) |-> write_busy[*8])
        else $error("busy flag dropped early");
    cover property ($fell(write_busy));
    cover property ($rose(data_out_oe));
    cover property ($fell(active_power));
endmodule

bind scfpt_core scfpt_sva #(
    .PROG_CYCLES (PROG_CYCLES),
    .WSTAT_CYCLES(WSTAT_CYCLES),
    .BULK_CYCLES (BULK_CYCLES),
    .SECT_CYCLES (SECT_CYCLES)
) scfpt_sva_inst (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .chip_select_n(chip_select_n),
    .data_out_oe  (data_out_oe),
    .active_power (active_power),
    .write_busy   (write_busy)
);

`default_nettype wire

/* scfpt_host.sv */
`timescale 1ns/1ps
`default_nettype none

module scfpt_host (
    input  wire logic ref_clk,       // System clock
    input  wire logic data_out,      // Device data
    input  wire logic active_power,  // Device power mode
    output var logic  chip_select_n, // Select, low active
    output var logic  serial_clock,  // Link clock
    output var logic  serial_data_in // Host data
);
    logic act_all;

    // Idle levels at time zero
    initial begin
        chip_select_n  = 1'b1;
        serial_clock   = 1'b0;
        serial_data_in = 1'b0;
        act_all        = 1'b1;
    end

    // One framed operation, clock still outside frames
    task automatic frame(input logic [39:0] bits, input int n,
                         output logic [7:0] rd);
        int i;
        rd = '0;
        act_all = 1'b1;
        chip_select_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (i = 0; i < n; i++) begin
            serial_data_in = bits[n-1-i];
            repeat (4) @(negedge ref_clk);
            serial_clock = 1'b1; // 80 ns period
            rd = {rd[6:0], data_out};
            act_all = act_all & active_power;
            repeat (4) @(negedge ref_clk);
            serial_clock = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        chip_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        repeat (12) @(negedge ref_clk); // 120 ns deselect
    endtask

    // Error restart: a bare select pulse, clock held still
    task automatic restart_pulse();
        act_all = 1'b0;
        chip_select_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        act_all = active_power;
        chip_select_n = 1'b1;
        repeat (12) @(negedge ref_clk);
    endtask
endmodule

`default_nettype wire

/* scfpt_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module scfpt_core_tb;
    import scfpt_pkg::*;
    localparam longint unsigned L_PROG = 300;
    localparam longint unsigned L_WSTAT = 400;
    localparam longint unsigned L_BULK = 500;
    localparam longint unsigned L_SECT = 350;
    localparam logic [39:0] RDSR = {24'h0, OP_RDSR, 8'h00};
    localparam logic [39:0] WREN = {32'h0, OP_WREN};
    logic ref_clk;
    logic rst;
    wire logic chip_select_n;
    wire logic serial_clock;
    wire logic serial_data_in;
    wire logic data_out;
    wire logic data_out_oe;
    wire logic data_line;
    wire logic active_power;
    wire logic write_busy;
    int error_cnt;
    int n_checks;
    longint unsigned run_len = 0;
    longint unsigned last_len = 0;
    logic [7:0] st;

    scfpt_core #(.PROG_CYCLES(L_PROG), .PROG_L_CYCLES(L_PROG),
        .WSTAT_CYCLES(L_WSTAT), .BULK_CYCLES(L_BULK),
        .BULK_L_CYCLES(L_BULK), .SECT_CYCLES(L_SECT),
        .SECT_L_CYCLES(L_SECT)) scfpt_core_inst (
        .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .data_out(data_out), .data_out_oe(data_out_oe),
        .active_power(active_power),
        .write_busy(write_busy));
    scfpt_host scfpt_host_inst (
        .ref_clk(ref_clk), .data_out(data_line), .active_power(active_power),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in));

    // Released data line shows the inverse of the last value
    assign data_line = data_out_oe ? data_out : ~data_out;

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Length of each busy run
    always @(negedge ref_clk) begin
        if (write_busy === 1'b1) begin
            run_len++;
        end else if (run_len != 0) begin
            last_len = run_len;
            run_len = 0;
        end
    end

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 1000 && write_busy !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
        if (write_busy !== 1'b0) begin
            error_cnt++;
            $display("ERROR wait_idle expected 0 seen %b", write_busy);
            give_verdict();
        end
        repeat (2) @(negedge ref_clk);
    endtask

    // Enable, run one cycle, poll status, time it
    task automatic t_job(input string nm, input logic [39:0] bits,
                         input int n, input longint unsigned len);
        scfpt_host_inst.frame(WREN, 8, st);
        scfpt_host_inst.frame(RDSR, 16, st);
        check("latch", 64'h2, st[1:0]);
        check("selected power", 64'h1, scfpt_host_inst.act_all);
        scfpt_host_inst.frame(bits, n, st);
        scfpt_host_inst.frame(RDSR, 16, st);
        check("status busy", 64'h1, st[1:0]);
        check("busy power", 64'h1, active_power);
        wait_idle();
        check(nm, len, last_len);
        check("standby", 64'h0, active_power);
        check("idle oe", 64'h0, data_out_oe);
        scfpt_host_inst.frame(RDSR, 16, st);
        check("status done", 64'h0, st[1:0]);
    endtask

    // No latch, dropped latch and a short frame start nothing
    task automatic t_refuse();
        scfpt_host_inst.frame({32'h0, OP_BULK}, 8, st);
        scfpt_host_inst.frame(WREN, 8, st);
        scfpt_host_inst.frame({32'h0, OP_WRDI}, 8, st);
        scfpt_host_inst.frame({32'h0, OP_BULK}, 8, st);
        scfpt_host_inst.frame(WREN, 8, st);
        scfpt_host_inst.frame({24'h0, OP_SECT, 8'h00}, 16, st);
        scfpt_host_inst.frame(RDSR, 16, st);
        check("refused status", 64'h2, st[1:0]);
    endtask

    // A bare select pulse starts nothing and keeps the latch
    task automatic t_restart();
        scfpt_host_inst.restart_pulse();
        check("pulse power", 64'h1, scfpt_host_inst.act_all);
        check("pulse standby", 64'h0, active_power);
        check("pulse busy", 64'h0, write_busy);
        check("pulse oe", 64'h0, data_out_oe);
        scfpt_host_inst.frame(RDSR, 16, st);
        check("pulse status", 64'h2, st[1:0]);
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        n_checks = 0;
        rst = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("reset power", 64'h0, active_power);
        check("reset busy", 64'h0, write_busy);
        t_job("program", {OP_PROG, 24'h000100, 8'ha5}, 40,
              L_PROG);
        t_job("status write", {24'h0, OP_WRSR, 8'h00}, 16,
              L_WSTAT);
        t_job("bulk erase", {32'h0, OP_BULK}, 8, L_BULK);
        t_job("sector erase", {8'h0, OP_SECT, 24'h010000}, 32,
              L_SECT);
        t_refuse();
        t_restart();
        give_verdict();
    end
endmodule

`default_nettype wire
